/* ddr2_cmd_defs.vh */
// Shared constants for the command state tracker.
`ifndef DDR2_CMD_DEFS_VH
`define DDR2_CMD_DEFS_VH
`define CMD_W              8
`define CMD_DESELECT       0
`define CMD_NOP            1
`define CMD_READ           2
`define CMD_WRITE          3
`define CMD_ACTIVATE       4
`define CMD_PRECHARGE      5
`define CMD_REFRESH        6
`define CMD_MODE_SET       7
`define ADDR_CTRL          8'h00
`define ADDR_STATUS        8'h04
`define ADDR_ERROR         8'h08
`define ADDR_ERR_COUNT     8'h0c
`define CTRL_TERM_ALLOW    0
`define CTRL_CHECK_EN      1
`define CTRL_RESET         2'h3
`define ERR_ILLEGAL        0
`define ERR_CKE_HOLD       1
`define ERR_SR_EXIT        2
`define ERR_BUSY_ENTRY     3
`define EMR_ONE_SEL        2'h1
`define CLOCK_ENABLE_MIN_HOLD  3
`define SR_EXIT_READ_DELAY     200
`define SR_EXIT_NONREAD_DELAY  40
`define BURST_CLKS         2
`endif

/* cmd_decode.v */
// Decodes the command pins into a one-hot command.
`timescale 1ns/1ps
`include "ddr2_cmd_defs.vh"
module cmd_decode (
  input  wire                cs_n,
  input  wire                ras_n,
  input  wire                cas_n,
  input  wire                we_n,
  output reg  [`CMD_W-1:0]   cmd
);
  always @* begin
    cmd = 8'h00;
    if (cs_n) begin
      cmd[`CMD_DESELECT] = 1'b1; // R21
    end else begin
      case ({ras_n, cas_n, we_n})
        3'b111: cmd[`CMD_NOP] = 1'b1; // R21
        3'b101: cmd[`CMD_READ] = 1'b1;
        3'b100: cmd[`CMD_WRITE] = 1'b1;
        3'b011: cmd[`CMD_ACTIVATE] = 1'b1;
        3'b010: cmd[`CMD_PRECHARGE] = 1'b1;
        3'b001: cmd[`CMD_REFRESH] = 1'b1;
        3'b000: cmd[`CMD_MODE_SET] = 1'b1;
        default: cmd[`CMD_NOP] = 1'b1;
      endcase
    end
  end
endmodule // cmd_decode

/* burst_counter.v */
// Counts the clocks of one data burst.
`timescale 1ns/1ps
module burst_counter #(
  parameter CNT_W = 3,
  parameter LEN   = 2
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             start,
  input  wire             stop,
  output wire             last
);
  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_next;
  always @* begin
    count_next = count_reg;
    if (start) begin
      count_next = LEN[CNT_W-1:0];
    end else if (stop) begin
      count_next = {CNT_W{1'b0}};
    end else if (count_reg != {CNT_W{1'b0}}) begin
      count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {CNT_W{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end
  assign last = (count_reg == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule // burst_counter

/* ddr2_cmd_state.v */
// Command and clock-enable state tracker with an APB register file.
`timescale 1ns/1ps
`include "ddr2_cmd_defs.vh"
// Overview of operation
// R1: Clock-enable action uses current and previous samples; low-low holds.
// R2: Command at an edge acts on the state held before it.
// R3: Unlisted state, clock-enable and command combinations are illegal.
// R4: Falling enable with no-op: active or precharge power down by banks.
// R5: Power-down entry and exit edges carry only deselect or no-op.
// R6: Self refresh only from idle, by refresh with falling enable.
// R7: Self refresh exit raises enable with deselect or no-op.
// R8: After self refresh exit only no-ops during the non-read delay.
// R9: No read until 200 clocks after self refresh exit.
// R10: No power down or self refresh during read or write bursts.
// R11: Enable level must be registered on three consecutive edges.
// R12: Termination input does not affect enable state transitions.
// R13: Termination is off throughout self refresh.
// R14: No refresh happens while in power down.
// R15: Enable stays high during output driver calibration.
// R16: Termination input must be valid in power down when enabled.
// R17: Mask low writes a beat; mask high inhibits it.
// R18: Idle accepts activate, precharge, refresh, register set; not read, write.
// R19: Banks active: read, write, precharge; activate open bank is illegal.
// R20: Bursts continue on no-op; same direction interrupts; rest illegal.
// R21: Commands decode from select, strobes, write enable at the edge.
// R22: Controller waits exit latency after leaving power down.
// R23: Controller issues only commands legal for the current state.
// R24: Commands illegal for the state are flagged and not executed.
module ddr2_cmd_state #(
  parameter SR_READ_CLKS    = `SR_EXIT_READ_DELAY,
  parameter SR_NONREAD_CLKS = `SR_EXIT_NONREAD_DELAY,
  parameter BURST_LEN       = `BURST_CLKS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        cke,
  input  wire        cs_n,
  input  wire        ras_n,
  input  wire        cas_n,
  input  wire        we_n,
  input  wire [1:0]  ba,
  input  wire        a10,
  input  wire        a2,
  input  wire        a6,
  input  wire        odt,
  input  wire        dm,
  input  wire        wdata_valid,
  output reg         term_on,
  output reg         refresh_pulse,
  output reg         wr_beat_commit,
  output reg         illegal_pulse
);
  localparam S_IDLE   = 7'h01;
  localparam S_ACTIVE = 7'h02;
  localparam S_READ   = 7'h04;
  localparam S_WRITE  = 7'h08;
  localparam S_PD_PRE = 7'h10;
  localparam S_PD_ACT = 7'h20;
  localparam S_SELF   = 7'h40;

  wire [`CMD_W-1:0] cmd;
  wire              burst_last;
  reg  [6:0]        state_reg;
  reg  [6:0]        state_next;
  reg  [3:0]        bank_reg;
  reg  [3:0]        bank_next;
  reg  [1:0]        bbank_reg;
  reg  [1:0]        bbank_next;
  reg               bclose_reg;
  reg               bclose_next;
  reg               cke_prev_reg;
  reg  [1:0]        hold_reg;
  reg  [1:0]        hold_next;
  reg  [7:0]        sr_cnt_reg;
  reg  [7:0]        sr_cnt_next;
  reg               emr_term_reg;
  reg               emr_term_next;
  reg  [1:0]        ctrl_reg;
  reg  [3:0]        err_reg;
  reg  [3:0]        err_set;
  reg               hold_err;
  reg  [15:0]       err_cnt_reg;
  reg               illegal;
  reg               burst_start;
  reg               burst_stop;
  reg               refresh_go;
  reg               is_nop;
  wire              apb_wr;
  wire              mapped;

  function [3:0] close_banks;
    input [3:0] open;
    input [1:0] sel;
    input       all;
    begin
      if (all) begin
        close_banks = 4'h0;
      end else begin
        close_banks = open & ~(4'h1 << sel);
      end
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `ADDR_CTRL) || (addr == `ADDR_STATUS) ||
                  (addr == `ADDR_ERROR) || (addr == `ADDR_ERR_COUNT);
    end
  endfunction

  cmd_decode u_dec (
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .cmd   (cmd)
  );

  burst_counter #(
    .CNT_W (3),
    .LEN   (BURST_LEN)
  ) u_burst (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (burst_start),
    .stop    (burst_stop),
    .last    (burst_last)
  );

  // Next state from the state before the edge and both enable samples.
  always @* begin
    state_next    = state_reg; // R2 R12
    bank_next     = bank_reg;
    bbank_next    = bbank_reg;
    bclose_next   = bclose_reg;
    emr_term_next = emr_term_reg;
    illegal       = 1'b0;
    burst_start   = 1'b0;
    burst_stop    = 1'b0;
    refresh_go    = 1'b0;
    err_set       = 4'h0;
    is_nop        = cmd[`CMD_DESELECT] | cmd[`CMD_NOP];
    case (state_reg)
      S_PD_PRE, S_PD_ACT: begin
        if (cke) begin
          if (!is_nop) begin
            illegal = 1'b1; // R5
          end
          state_next = (state_reg == S_PD_PRE) ? S_IDLE : S_ACTIVE;
        end
      end
      S_SELF: begin
        if (cke) begin
          if (!is_nop) begin
            illegal = 1'b1; // R7
          end
          state_next = S_IDLE;
        end
      end
      default: begin
        if (state_reg == S_READ || state_reg == S_WRITE) begin
          if (burst_last) begin
            if (bclose_reg) begin
              bank_next = close_banks(bank_reg, bbank_reg, 1'b0);
            end
            if (bclose_reg &&
                close_banks(bank_reg, bbank_reg, 1'b0) == 4'h0) begin
              state_next = S_IDLE;
            end else begin
              state_next = S_ACTIVE;
            end
          end
        end
        if (cke_prev_reg && !cke) begin
          if (is_nop) begin
            case (state_reg)
              S_IDLE:   state_next = S_PD_PRE; // R4
              S_ACTIVE: state_next = S_PD_ACT; // R4
              default:  err_set[`ERR_BUSY_ENTRY] = 1'b1; // R10
            endcase
          end else if (cmd[`CMD_REFRESH] && state_reg == S_IDLE) begin
            state_next = S_SELF; // R6
          end else begin
            illegal = 1'b1; // R3
            if (cmd[`CMD_REFRESH]) begin
              err_set[`ERR_BUSY_ENTRY] = 1'b1; // R10
            end
          end
        end else if (!is_nop) begin
          case (state_reg)
            S_IDLE: begin
              if (cmd[`CMD_ACTIVATE]) begin
                bank_next  = 4'h1 << ba; // R18
                state_next = S_ACTIVE;
              end else if (cmd[`CMD_REFRESH]) begin
                refresh_go = cke_prev_reg & cke; // R18
              end else if (cmd[`CMD_MODE_SET]) begin
                if (ba == `EMR_ONE_SEL) begin
                  emr_term_next = a2 | a6; // R16
                end
              end else if (!cmd[`CMD_PRECHARGE]) begin
                illegal = 1'b1; // R18
              end
            end
            S_ACTIVE: begin
              if (cmd[`CMD_READ] || cmd[`CMD_WRITE]) begin
                if (bank_reg[ba]) begin
                  burst_start = 1'b1; // R19
                  bbank_next  = ba;
                  bclose_next = a10;
                  state_next  = cmd[`CMD_READ] ? S_READ : S_WRITE;
                end else begin
                  illegal = 1'b1;
                end
              end else if (cmd[`CMD_ACTIVATE]) begin
                if (bank_reg[ba]) begin
                  illegal = 1'b1; // R19
                end else begin
                  bank_next = bank_reg | (4'h1 << ba);
                end
              end else if (cmd[`CMD_PRECHARGE]) begin
                bank_next = close_banks(bank_reg, ba, a10); // R19
                if (close_banks(bank_reg, ba, a10) == 4'h0) begin
                  state_next = S_IDLE;
                end
              end else begin
                illegal = 1'b1; // R19
              end
            end
            S_READ, S_WRITE: begin
              if ((cmd[`CMD_READ] && state_reg == S_READ) ||
                  (cmd[`CMD_WRITE] && state_reg == S_WRITE)) begin
                if (bank_reg[ba]) begin
                  burst_start = 1'b1; // R20
                  bbank_next  = ba;
                  bclose_next = a10;
                  state_next  = state_reg;
                end else begin
                  illegal = 1'b1;
                end
              end else begin
                illegal = 1'b1; // R20
              end
            end
            default: begin
              illegal    = 1'b1;
              state_next = S_IDLE;
            end
          endcase
        end
      end
    endcase
    if (illegal) begin
      // R24
      state_next    = (state_reg == S_PD_PRE) ? S_IDLE :
                      (state_reg == S_PD_ACT) ? S_ACTIVE :
                      (state_reg == S_SELF) ? S_IDLE : state_next;
      bank_next     = (state_reg == S_READ || state_reg == S_WRITE) ?
                      bank_next : bank_reg;
      emr_term_next = emr_term_reg;
      err_set[`ERR_ILLEGAL] = 1'b1;
    end
    if (state_reg == S_READ || state_reg == S_WRITE) begin
      burst_stop = (state_next != S_READ) && (state_next != S_WRITE);
    end
    if (sr_cnt_reg != 8'h00) begin
      if (cmd[`CMD_READ]) begin
        err_set[`ERR_SR_EXIT] = 1'b1; // R9
      end
      if (!is_nop && sr_cnt_reg > (SR_READ_CLKS - SR_NONREAD_CLKS)) begin
        err_set[`ERR_SR_EXIT] = 1'b1; // R8
      end
    end
  end

  // Enable hold check and self refresh exit timer.
  always @* begin
    hold_next   = hold_reg;
    sr_cnt_next = sr_cnt_reg;
    hold_err    = 1'b0;
    if (cke != cke_prev_reg) begin
      hold_next = 2'h1;
      if (hold_reg < `CLOCK_ENABLE_MIN_HOLD) begin
        hold_err = 1'b1; // R11
      end
    end else if (hold_reg < `CLOCK_ENABLE_MIN_HOLD) begin
      hold_next = hold_reg + 2'h1;
    end
    if (state_reg == S_SELF && state_next == S_IDLE) begin
      sr_cnt_next = SR_READ_CLKS[7:0];
    end else if (sr_cnt_reg != 8'h00) begin
      sr_cnt_next = sr_cnt_reg - 8'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= S_IDLE;
      bank_reg     <= 4'h0;
      bbank_reg    <= 2'h0;
      bclose_reg   <= 1'b0;
      cke_prev_reg <= 1'b1;
      hold_reg     <= 2'h3;
      sr_cnt_reg   <= 8'h00;
      emr_term_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      bank_reg     <= bank_next;
      bbank_reg    <= bbank_next;
      bclose_reg   <= bclose_next;
      cke_prev_reg <= cke; // R1
      hold_reg     <= hold_next;
      sr_cnt_reg   <= sr_cnt_next;
      emr_term_reg <= emr_term_next;
    end
  end

  // Pin-side outputs; termination is held off whenever the next state is self refresh.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_on        <= 1'b0;
      refresh_pulse  <= 1'b0;
      wr_beat_commit <= 1'b0;
      illegal_pulse  <= 1'b0;
    end else begin
      term_on        <= odt & emr_term_reg & ctrl_reg[`CTRL_TERM_ALLOW] &
                        (state_next != S_SELF); // R13
      refresh_pulse  <= refresh_go; // R14
      wr_beat_commit <= (state_reg == S_WRITE) & wdata_valid & ~dm; // R17
      illegal_pulse  <= illegal & ctrl_reg[`CTRL_CHECK_EN]; // R24
    end
  end

  // APB slave: zero wait states, read data latched in the setup cycle.
  assign pready  = 1'b1;
  assign mapped  = is_mapped(paddr);
  assign pslverr = psel & penable & ~mapped;
  assign apb_wr  = psel & penable & pwrite & mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= `CTRL_RESET;
      err_reg     <= 4'h0;
      err_cnt_reg <= 16'h0000;
      prdata      <= 32'h0000_0000;
    end else begin
      if (apb_wr && paddr == `ADDR_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (ctrl_reg[`CTRL_CHECK_EN]) begin
        err_reg <= err_set | {2'b00, hold_err, 1'b0} |
                   (err_reg & ~((apb_wr && paddr == `ADDR_ERROR) ?
                                pwdata[3:0] : 4'h0));
      end else if (apb_wr && paddr == `ADDR_ERROR) begin
        err_reg <= err_reg & ~pwdata[3:0];
      end
      if (ctrl_reg[`CTRL_CHECK_EN] && illegal) begin
        err_cnt_reg <= err_cnt_reg + 16'h0001;
      end else if (apb_wr && paddr == `ADDR_ERR_COUNT) begin
        err_cnt_reg <= 16'h0000;
      end
      if (psel && !penable) begin
        case (paddr)
          `ADDR_CTRL:      prdata <= {30'h0, ctrl_reg};
          `ADDR_STATUS:    prdata <= {12'h0, sr_cnt_reg, bank_reg, 1'b0,
                                      state_reg};
          `ADDR_ERROR:     prdata <= {28'h0, err_reg};
          `ADDR_ERR_COUNT: prdata <= {16'h0, err_cnt_reg};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // ddr2_cmd_state

/* ddr2_cmd_state_asserts.sv */
// Port-level checks for the command state tracker.
`timescale 1ns/1ps
module ddr2_cmd_state_chk (
  input wire pclk,
  input wire presetn,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire odt,
  input wire dm,
  input wire wdata_valid,
  input wire term_on,
  input wire refresh_pulse,
  input wire wr_beat_commit,
  input wire illegal_pulse
);
  wire is_ref = !cs_n && !ras_n && !cas_n && we_n;
  wire is_act = !cs_n && !ras_n && cas_n && we_n;
  wire is_rw  = !cs_n && ras_n && !cas_n;
  wire is_nop = cs_n || (ras_n && cas_n && we_n);
  reg  act_seen;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      act_seen <= 1'b0;
    else if (is_act && cke)
      act_seen <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence sr_entry;
    cke ##1 (!cke && is_ref);
  endsequence
  AST_SR_TERM_OFF: assert property (
    sr_entry ##1 !illegal_pulse |-> !term_on)
    else $error("termination on in self refresh");
  AST_IDLE_RDWR: assert property (
    is_rw && cke && $past(cke) && !act_seen |=> illegal_pulse)
    else $error("read or write in idle not flagged");
  AST_NOP_LEGAL: assert property (
    is_nop && cke && $past(cke) |=> !illegal_pulse)
    else $error("no-op flagged illegal");
  AST_REF_CAUSE: assert property (
    refresh_pulse |-> $past(is_ref && cke))
    else $error("refresh pulse without refresh command");
  AST_NO_REF_LOW: assert property (!cke |=> !refresh_pulse)
    else $error("refresh while clock enable low");
  AST_DM_INHIBIT: assert property (
    wdata_valid && dm |=> !wr_beat_commit)
    else $error("masked beat written");
  AST_BEAT_CAUSE: assert property (
    wr_beat_commit |-> $past(wdata_valid && !dm))
    else $error("beat written without data");
  AST_TERM_CAUSE: assert property (term_on |-> $past(odt))
    else $error("termination on without odt");
endmodule // ddr2_cmd_state_chk
bind ddr2_cmd_state ddr2_cmd_state_chk u_ddr2_cmd_state_chk (
  .pclk(pclk), .presetn(presetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .odt(odt), .dm(dm),
  .wdata_valid(wdata_valid), .term_on(term_on),
  .refresh_pulse(refresh_pulse), .wr_beat_commit(wr_beat_commit),
  .illegal_pulse(illegal_pulse));

/* ddr2_ctrl_model.sv */
// Memory controller model that drives commands and clock enable.
`timescale 1ns/1ps
`include "ddr2_cmd_defs.vh"
module ddr2_ctrl_model (
  input  wire       pclk,
  output reg        cke,
  output reg        cs_n,
  output reg        ras_n,
  output reg        cas_n,
  output reg        we_n,
  output reg  [1:0] ba,
  output reg        a10,
  output reg        a2,
  output reg        a6
);
  reg lvl;
  int age;
  initial begin
    {cke, lvl, cs_n, ras_n, cas_n, we_n} = 6'b110111;
    {ba, a10, a2, a6} = 5'h00;
    age = 3;
  end
  // One command a cycle, pins changed just after the edge.
  task automatic drive(input [2:0] c, input k, input [1:0] b, input a,
                       input o);
    reg [3:0] p;
    @(posedge pclk);
    case (c)
      `CMD_DESELECT:  p = {1'b1, ~ras_n, ~cas_n, ~we_n};
      `CMD_READ:      p = 4'h5;
      `CMD_WRITE:     p = 4'h4;
      `CMD_ACTIVATE:  p = 4'h3;
      `CMD_PRECHARGE: p = 4'h2;
      `CMD_REFRESH:   p = 4'h1;
      `CMD_MODE_SET:  p = 4'h0;
      default:        p = 4'h7;
    endcase
    {cs_n, ras_n, cas_n, we_n} <= p;
    cke <= k;
    ba <= b;
    a10 <= a;
    a2 <= o;
    a6 <= 1'b0;
    age = (k == lvl) ? age + 1 : 1;
    lvl = k;
  endtask
  // Issues the requested command; an enable change first waits for the enable hold to run out.
  task automatic issue(input [2:0] c, input k, input [1:0] b, input a,
                       input o);
    while (k != lvl && age < `CLOCK_ENABLE_MIN_HOLD)
      drive(`CMD_NOP, lvl, 2'h0, 1'b0, 1'b0);
    drive(c, k, b, a, o);
  endtask
  task automatic nop(input int n);
    repeat (n) drive(`CMD_NOP, lvl, 2'h0, 1'b0, 1'b0);
  endtask
endmodule // ddr2_ctrl_model

/* ddr2_cmd_state_bench.sv */
// Self-checking bench for the command state tracker.
`timescale 1ns/1ps
`include "ddr2_cmd_defs.vh"
module ddr2_cmd_state_bench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  reg         odt = 1'b1;
  reg         dm = 1'b0;
  reg         wdata_valid = 1'b0;
  reg  [31:0] q;
  reg         serr;
  wire [31:0] prdata;
  wire [1:0]  ba;
  wire        pready, pslverr, cke, cs_n, ras_n, cas_n, we_n, a10, a2, a6;
  wire        term_on, refresh_pulse, wr_beat_commit, illegal_pulse;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         ref_seen = 0;
  int         beats = 0;
  int         ill_seen = 0;
  int         i;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (refresh_pulse === 1'b1)
      ref_seen <= ref_seen + 1;
    if (wr_beat_commit === 1'b1)
      beats <= beats + 1;
    if (illegal_pulse === 1'b1)
      ill_seen <= ill_seen + 1;
  end
  ddr2_cmd_state #(.SR_READ_CLKS(20), .SR_NONREAD_CLKS(5)) u_ddr2_cmd_state (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10),
    .a2(a2), .a6(a6), .odt(odt), .dm(dm), .wdata_valid(wdata_valid),
    .term_on(term_on), .refresh_pulse(refresh_pulse),
    .wr_beat_commit(wr_beat_commit), .illegal_pulse(illegal_pulse));
  ddr2_ctrl_model u_ddr2_ctrl_model (.pclk(pclk), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10),
    .a2(a2), .a6(a6));
  task cmd(input int c, input int k, input int b, input int a, input int o);
    u_ddr2_ctrl_model.issue(c[2:0], k[0], b[1:0], a[0], o[0]);
  endtask
  task nops(input int n);
    u_ddr2_ctrl_model.nop(n);
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    int n;
    nops(1);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end else begin
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task st(input [11:0] e);
    rd(`ADDR_STATUS);
    check(q & 32'hfff, {20'h0, e});
  endtask
  task clr;
    apb(1'b1, `ADDR_ERROR, 32'hf);
    apb(1'b1, `ADDR_ERR_COUNT, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ADDR_CTRL);
    check(q, 32'h3);
    st(12'h001);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    check({31'h0, serr}, 32'h1);
    rd(8'h10);
    check(q, 32'h0);
    for (i = `CMD_READ; i <= `CMD_WRITE; i++)
      cmd(i, 1, 0, 0, 0);
    cmd(`CMD_PRECHARGE, 1, 0, 0, 0);
    cmd(`CMD_REFRESH, 1, 0, 0, 0);
    cmd(`CMD_MODE_SET, 1, 1, 0, 1);
    nops(3);
    check(ref_seen, 1);
    check({31'h0, term_on}, 1);
    odt <= 1'b0;
    nops(2);
    check({31'h0, term_on}, 0);
    odt <= 1'b1;
    rd(`ADDR_ERR_COUNT);
    check(q, 2);
    rd(`ADDR_ERROR);
    check(q, 1);
    clr;
    cmd(`CMD_NOP, 0, 0, 0, 0);
    cmd(`CMD_REFRESH, 0, 0, 0, 0);
    st(12'h010);
    check(ref_seen, 1);
    check({31'h0, term_on}, 1);
    cmd(`CMD_DESELECT, 1, 0, 0, 0);
    st(12'h001);
    cmd(`CMD_REFRESH, 0, 0, 0, 0);
    st(12'h040);
    check({31'h0, term_on}, 0);
    cmd(`CMD_NOP, 1, 0, 0, 0);
    nops(6);
    cmd(`CMD_ACTIVATE, 1, 0, 0, 0);
    cmd(`CMD_READ, 1, 0, 0, 0);
    nops(3);
    rd(`ADDR_ERROR);
    check(q, 4);
    clr;
    nops(20);
    for (i = `CMD_ACTIVATE; i <= `CMD_MODE_SET; i++)
      if (i != `CMD_PRECHARGE) cmd(i, 1, 0, 0, 0);
    st(12'h102);
    cmd(`CMD_NOP, 0, 0, 0, 0);
    st(12'h120);
    cmd(`CMD_NOP, 1, 0, 0, 0);
    st(12'h102);
    cmd(`CMD_WRITE, 1, 0, 0, 0);
    cmd(`CMD_READ, 1, 0, 0, 0);
    dm <= 1'b0;
    wdata_valid <= 1'b1;
    nops(1);
    dm <= 1'b1;
    nops(1);
    wdata_valid <= 1'b0;
    nops(3);
    check(beats, 1);
    for (i = `CMD_WRITE; i <= `CMD_MODE_SET; i++) begin
      cmd(`CMD_READ, 1, 0, 0, 0);
      cmd(i, 1, 0, 0, 0);
      nops(3);
    end
    st(12'h102);
    rd(`ADDR_ERR_COUNT);
    check(q, 9);
    cmd(`CMD_WRITE, 1, 0, 0, 0);
    cmd(`CMD_NOP, 0, 0, 0, 0);
    cmd(`CMD_NOP, 1, 0, 0, 0);
    rd(`ADDR_ERROR);
    check(q & 32'h8, 32'h8);
    cmd(`CMD_PRECHARGE, 1, 0, 1, 0);
    nops(2);
    st(12'h001);
    check({31'h0, term_on}, 1);
    apb(1'b1, `ADDR_CTRL, 32'h0);
    cmd(`CMD_READ, 1, 0, 0, 0);
    nops(2);
    check({31'h0, term_on}, 0);
    rd(`ADDR_ERR_COUNT);
    check(q, 9);
    check(ill_seen, 11);
    tally_and_finish();
  end
endmodule // ddr2_cmd_state_bench
